// File: rtl/tmc_ctrl.sv
// Purpose: configuration, alert status, alarm pins and conversion scheduling
// Assumes: register requests and conversion results come from logic on clk_sys
// Notes:   serial clock pin is sampled only to watch for a stuck bus
`timescale 1ns/100ps
// Behaviour
// R1: a one in the halt bit of control one stops new conversions and holds standby.
// R2: writing one to the restore bit returns all registers to power-on state and it reads zero.
// R3: the guard-off bit at zero enables the bus timeout and at one disables it.
// R4: the fast bit makes the scheduler visit remote channel one between every other channel.
// R5: the cancel bit requests series-resistance cancellation on channel one conversions only.
// R6: alarm mask bit 6 keeps a local crossing off the threshold alarm pin.
// R7: alarm mask bits 3 to 0 keep remote channels 4 to 1 off the threshold alarm pin.
// R8: overtemp mask bits 3 and 0 keep channels 4 and 1 off the overtemp pin.
// R9: a local conversion above its alert limit sets status bit 6.
// R10: a remote conversion above its alert limit sets status bit 3 to 0 for channel 4 to 1.
// R11: all four registers come out of power-on reset at zero.
// R12: the four registers are selected by command index 41, 42, 43 and 44 hex.
// R13: a status read clears the flags and a still-present crossing sets them again.
// R14: the alarm pin follows new flags and releases on a status read or alert response.
// R15: the overtemp pin stays asserted until the temperature falls below limit minus four.
// R16: reserved bits read as zero and ignore writes.
// R17: masks only gate the pins and never stop a status flag being recorded.
module tmc_ctrl #(
  parameter int unsigned BUS_TIMEOUT_US = tmc_pkg::BUS_TIMEOUT_US
) (
  input  wire logic                   clk_sys,
  input  wire logic                   nrst,
  input  wire logic                   ce,
  input  wire tmc_pkg::tmc_reg_req_t  reg_req,
  input  wire logic                   ara_ack,
  input  wire tmc_pkg::tmc_conv_res_t conv_res,
  input  wire logic                   smbclk_pin,
  output logic [7:0]                  reg_rdata,
  output logic                        conv_start,
  output logic [2:0]                  conv_chan,
  output logic                        conv_res_cancel,
  output logic                        threshold_alarm_o,
  output logic                        threshold_alarm_oe,
  output logic                        overtemp_o,
  output logic                        overtemp_oe,
  output logic                        bus_timeout
);

  localparam int unsigned TIMEOUT_CYCLES =
    (BUS_TIMEOUT_US * 32'd1000 + tmc_pkg::CLK_PERIOD_NS - 1) / tmc_pkg::CLK_PERIOD_NS;

  logic [7:0]                ctrl_one_reg;
  logic [7:0]                alarm_mask_reg;
  logic [7:0]                ot_mask_reg;
  logic [7:0]                alarm_stat_reg;
  logic                      srst_reg;
  logic                      alarm_pend_reg;
  logic [1:0]                ot_hold_reg;
  logic [2:0]                round_reg;
  tmc_pkg::tmc_sched_state_t state_reg;
  logic [7:0]                stat_set;
  logic                      wr_ctrl;
  logic                      rd_stat;
  logic                      halt;
  logic                      fast;
  logic                      scl_sync;
  logic [2:0]                pick_chan;
  logic [2:0]                pick_round;

  assign halt    = ctrl_one_reg[tmc_pkg::CTRL_HALT_BIT];
  assign fast    = ctrl_one_reg[tmc_pkg::CTRL_FAST_BIT];
  assign wr_ctrl = reg_req.wr && (reg_req.cmd == tmc_pkg::CMD_CTRL_ONE);
  assign rd_stat = reg_req.rd && (reg_req.cmd == tmc_pkg::CMD_ALARM_STAT);

  // per-channel alert crossings of the result just delivered
  always_comb begin
    stat_set = 8'h00;
    if (conv_res.valid && ($signed(conv_res.temp) > $signed(conv_res.alert_limit))) begin
      if (conv_res.chan == tmc_pkg::CHAN_LOCAL) begin
        stat_set[tmc_pkg::LOCAL_STAT_BIT] = 1'b1; // see R9
      end else if (conv_res.chan <= tmc_pkg::CHAN_LAST) begin
        stat_set[conv_res.chan - 3'h1] = 1'b1; // see R10
      end
    end
  end

  // restore takes effect one cycle after the write, then drops by itself
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      srst_reg <= 1'b0;
    end else if (ce) begin
      srst_reg <= wr_ctrl && reg_req.wdata[tmc_pkg::CTRL_RESTORE_BIT] && !srst_reg; // see R2
    end
  end

  // configuration writes
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_one_reg   <= tmc_pkg::CTRL_ONE_RST; // see R11
      alarm_mask_reg <= tmc_pkg::ALARM_MASK_RST;
      ot_mask_reg    <= tmc_pkg::OT_MASK_RST;
    end else if (ce) begin
      if (srst_reg) begin
        ctrl_one_reg   <= tmc_pkg::CTRL_ONE_RST; // see R2
        alarm_mask_reg <= tmc_pkg::ALARM_MASK_RST;
        ot_mask_reg    <= tmc_pkg::OT_MASK_RST;
      end else if (wr_ctrl) begin // see R12
        ctrl_one_reg <= reg_req.wdata & tmc_pkg::CTRL_ONE_WMASK; // see R16
      end else if (reg_req.wr && reg_req.cmd == tmc_pkg::CMD_ALARM_MASK) begin
        alarm_mask_reg <= reg_req.wdata & tmc_pkg::ALARM_MASK_WMASK;
      end else if (reg_req.wr && reg_req.cmd == tmc_pkg::CMD_OT_MASK) begin
        ot_mask_reg <= reg_req.wdata & tmc_pkg::OT_MASK_WMASK;
      end
    end
  end

  // sticky flags; a crossing in the clearing cycle survives the read
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      alarm_stat_reg <= tmc_pkg::ALARM_STAT_RST;
    end else if (ce) begin
      if (srst_reg) begin
        alarm_stat_reg <= tmc_pkg::ALARM_STAT_RST;
      end else if (rd_stat) begin
        alarm_stat_reg <= stat_set; // see R13
      end else begin
        alarm_stat_reg <= alarm_stat_reg | stat_set; // see R17
      end
    end
  end

  // register read data, unmapped commands read zero
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      if (reg_req.cmd == tmc_pkg::CMD_CTRL_ONE) begin
        reg_rdata <= ctrl_one_reg;
      end else if (reg_req.cmd == tmc_pkg::CMD_ALARM_MASK) begin
        reg_rdata <= alarm_mask_reg;
      end else if (reg_req.cmd == tmc_pkg::CMD_OT_MASK) begin
        reg_rdata <= ot_mask_reg;
      end else if (reg_req.cmd == tmc_pkg::CMD_ALARM_STAT) begin
        reg_rdata <= alarm_stat_reg;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // alarm pin: raised by a new unmasked flag, dropped by read or alert response
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      alarm_pend_reg <= 1'b0;
    end else if (ce) begin
      if (srst_reg) begin
        alarm_pend_reg <= 1'b0;
      end else if (|(stat_set & ~alarm_mask_reg)) begin
        alarm_pend_reg <= 1'b1; // see R6, R7, R14
      end else if (rd_stat || ara_ack) begin
        alarm_pend_reg <= 1'b0; // see R14
      end
    end
  end

  // overtemp hold with four-degree hysteresis, channels one and four
  for (genvar i = 0; i < 2; i++) begin : g_ot
    localparam logic [2:0] CH = (i == 0) ? tmc_pkg::OT_CHAN_ONE : tmc_pkg::OT_CHAN_FOUR;
    logic [8:0] release_lvl;
    logic       hit;
    assign release_lvl = {conv_res.ot_limit[7], conv_res.ot_limit} - tmc_pkg::OT_HYST_DEGC;
    assign hit         = conv_res.valid && (conv_res.chan == CH);
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        ot_hold_reg[i] <= 1'b0;
      end else if (ce) begin
        if (srst_reg) begin
          ot_hold_reg[i] <= 1'b0;
        end else if (hit && ($signed(conv_res.temp) > $signed(conv_res.ot_limit))) begin
          ot_hold_reg[i] <= 1'b1;
        end else if (hit && ($signed({conv_res.temp[7], conv_res.temp})
                             < $signed(release_lvl))) begin
          ot_hold_reg[i] <= 1'b0; // see R15
        end
      end
    end
  end

  // open-drain pins pull low while asserted
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      threshold_alarm_o  <= 1'b0;
      threshold_alarm_oe <= 1'b0;
      overtemp_o         <= 1'b0;
      overtemp_oe        <= 1'b0;
    end else if (ce) begin
      threshold_alarm_o  <= 1'b0;
      overtemp_o         <= 1'b0;
      threshold_alarm_oe <= alarm_pend_reg && !srst_reg;
      overtemp_oe        <= !srst_reg && // see R8
        ((ot_hold_reg[0] && !ot_mask_reg[tmc_pkg::OT_MASK_ONE_BIT]) ||
         (ot_hold_reg[1] && !ot_mask_reg[tmc_pkg::OT_MASK_FOUR_BIT]));
    end
  end

  // next channel: fast mode slips channel one in after every other channel
  always_comb begin
    pick_round = (round_reg >= tmc_pkg::CHAN_LAST) ? tmc_pkg::CHAN_LOCAL : round_reg + 3'h1;
    if (fast && pick_round == tmc_pkg::CHAN_REMOTE_ONE) begin
      pick_round = pick_round + 3'h1;
    end
    if (fast && conv_chan != tmc_pkg::CHAN_REMOTE_ONE) begin
      pick_chan = tmc_pkg::CHAN_REMOTE_ONE; // see R4
    end else begin
      pick_chan = pick_round;
    end
  end

  // scheduler; a halt lets the running conversion finish
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg       <= tmc_pkg::SCH_IDLE;
      round_reg       <= tmc_pkg::CHAN_LAST;
      conv_start      <= 1'b0;
      conv_chan       <= tmc_pkg::CHAN_LAST;
      conv_res_cancel <= 1'b0;
    end else if (ce) begin
      conv_start <= 1'b0;
      if (srst_reg) begin
        state_reg       <= tmc_pkg::SCH_IDLE;
        round_reg       <= tmc_pkg::CHAN_LAST;
        conv_chan       <= tmc_pkg::CHAN_LAST;
        conv_res_cancel <= 1'b0;
      end else begin
        case (state_reg)
          tmc_pkg::SCH_IDLE: begin
            if (!halt) begin // see R1
              state_reg <= tmc_pkg::SCH_START;
            end
          end
          tmc_pkg::SCH_START: begin
            conv_start      <= 1'b1;
            conv_chan       <= pick_chan;
            conv_res_cancel <= (pick_chan == tmc_pkg::CHAN_REMOTE_ONE) &&
                               ctrl_one_reg[tmc_pkg::CTRL_CANCEL_BIT]; // see R5
            if (pick_chan != tmc_pkg::CHAN_REMOTE_ONE || !fast) begin
              round_reg <= pick_chan;
            end
            state_reg <= tmc_pkg::SCH_WAIT;
          end
          tmc_pkg::SCH_WAIT: begin
            if (conv_res.valid && conv_res.chan == conv_chan) begin
              state_reg <= halt ? tmc_pkg::SCH_IDLE : tmc_pkg::SCH_START; // see R1
            end
          end
          default: begin
            state_reg <= tmc_pkg::SCH_IDLE;
          end
        endcase
      end
    end
  end

  tmc_sync #(
    .W (1)
  ) u_scl_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .ce      (ce),
    .din     (smbclk_pin),
    .dout    (scl_sync)
  );

  // watchdog only runs while the guard-off bit is clear
  tmc_bus_timeout #(
    .CYCLES (TIMEOUT_CYCLES)
  ) u_timeout (
    .clk_sys       (clk_sys),
    .nrst          (nrst),
    .ce            (ce),
    .clr           (srst_reg),
    .enable        (!ctrl_one_reg[tmc_pkg::CTRL_GUARD_BIT]), // see R3
    .scl           (scl_sync),
    .timeout_pulse (bus_timeout)
  );

  sequence s_restore_wr;
    ce && wr_ctrl && reg_req.wdata[tmc_pkg::CTRL_RESTORE_BIT] && !srst_reg;
  endsequence

  sequence s_restore_done;
    srst_reg ##1 (ctrl_one_reg == 8'h00 && alarm_stat_reg == 8'h00 && !srst_reg);
  endsequence

  a_restore_self_clear: assert property (@(posedge clk_sys) disable iff (!nrst) // see R2, R11
    s_restore_wr ##1 ce |-> s_restore_done)
    else $error("restore did not clear registers or itself");

  a_halt_no_start: assert property (@(posedge clk_sys) disable iff (!nrst) // see R1
    (ce && !srst_reg && halt && (state_reg == tmc_pkg::SCH_IDLE ||
     (state_reg == tmc_pkg::SCH_WAIT && conv_res.valid && conv_res.chan == conv_chan)))
    |=> state_reg == tmc_pkg::SCH_IDLE && !conv_start)
    else $error("conversion started while halted");

  a_guard_off_quiet: assert property (@(posedge clk_sys) disable iff (!nrst) // see R3
    ctrl_one_reg[tmc_pkg::CTRL_GUARD_BIT] && $past(ctrl_one_reg[tmc_pkg::CTRL_GUARD_BIT])
    |-> !bus_timeout)
    else $error("bus timeout fired while disabled");

  a_fast_ch_one: assert property (@(posedge clk_sys) disable iff (!nrst) // see R4
    (ce && !srst_reg && fast && state_reg == tmc_pkg::SCH_START &&
     conv_chan != tmc_pkg::CHAN_REMOTE_ONE) |=> conv_chan == tmc_pkg::CHAN_REMOTE_ONE)
    else $error("fast mode skipped channel one");

  a_cancel_ch_one: assert property (@(posedge clk_sys) disable iff (!nrst) // see R5
    conv_start |-> conv_res_cancel ==
      (conv_chan == tmc_pkg::CHAN_REMOTE_ONE && $past(ctrl_one_reg[tmc_pkg::CTRL_CANCEL_BIT])))
    else $error("cancel request on wrong channel");

  a_alarm_mask_gate: assert property (@(posedge clk_sys) disable iff (!nrst) // see R6, R7, R14
    $rose(alarm_pend_reg) |-> $past(|(stat_set & ~alarm_mask_reg)))
    else $error("alarm raised by masked or absent crossing");

  a_ot_mask_gate: assert property (@(posedge clk_sys) disable iff (!nrst) // see R8
    $past(ce) && $past((ot_mask_reg[tmc_pkg::OT_MASK_ONE_BIT] || !ot_hold_reg[0]) &&
                       (ot_mask_reg[tmc_pkg::OT_MASK_FOUR_BIT] || !ot_hold_reg[1]))
    |-> !overtemp_oe)
    else $error("masked overtemp reached the pin");

  a_status_records: assert property (@(posedge clk_sys) disable iff (!nrst) // see R9, R10, R17
    (ce && !srst_reg && |stat_set) |=> ((alarm_stat_reg & $past(stat_set)) == $past(stat_set)))
    else $error("crossing not recorded in status");

  a_read_clears: assert property (@(posedge clk_sys) disable iff (!nrst) // see R13
    (ce && rd_stat && stat_set == 8'h00) |=> alarm_stat_reg == 8'h00)
    else $error("status read did not clear flags");

  a_ot_hysteresis: assert property (@(posedge clk_sys) disable iff (!nrst) // see R15
    (ce && !srst_reg && ot_hold_reg[0] && !(conv_res.valid &&
     conv_res.chan == tmc_pkg::OT_CHAN_ONE)) |=> ot_hold_reg[0])
    else $error("overtemp released without a cooler reading");

  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!nrst) // see R16
    (ctrl_one_reg & ~tmc_pkg::CTRL_ONE_WMASK) == 8'h00 &&
    (alarm_stat_reg & ~tmc_pkg::ALARM_STAT_MASK) == 8'h00)
    else $error("reserved bit set");

endmodule : tmc_ctrl

// File: rtl/tmc_pkg.sv
// Purpose: shared constants, types and carriers of the temperature monitor control block
// Assumes: 8-bit registers selected by a command index from the bus protocol engine
// Notes:   temperatures and limits are two's complement degrees
package tmc_pkg;

  localparam logic [7:0] CMD_CTRL_ONE      = 8'h41;
  localparam logic [7:0] CMD_ALARM_MASK    = 8'h42;
  localparam logic [7:0] CMD_OT_MASK       = 8'h43;
  localparam logic [7:0] CMD_ALARM_STAT    = 8'h44;

  localparam int         CTRL_HALT_BIT     = 7;
  localparam int         CTRL_RESTORE_BIT  = 6;
  localparam int         CTRL_GUARD_BIT    = 5;
  localparam int         CTRL_FAST_BIT     = 4;
  localparam int         CTRL_CANCEL_BIT   = 3;
  localparam int         LOCAL_STAT_BIT    = 6;

  // restore bit is never stored, so it reads back as zero
  localparam logic [7:0] CTRL_ONE_WMASK    = 8'hb8;
  localparam logic [7:0] ALARM_MASK_WMASK  = 8'h4f;
  localparam logic [7:0] OT_MASK_WMASK     = 8'h09;
  localparam logic [7:0] ALARM_STAT_MASK   = 8'h4f;

  localparam logic [7:0] CTRL_ONE_RST      = 8'h00;
  localparam logic [7:0] ALARM_MASK_RST    = 8'h00;
  localparam logic [7:0] OT_MASK_RST       = 8'h00;
  localparam logic [7:0] ALARM_STAT_RST    = 8'h00;

  localparam logic [2:0] CHAN_LOCAL        = 3'h0;
  localparam logic [2:0] CHAN_REMOTE_ONE   = 3'h1;
  localparam logic [2:0] CHAN_LAST         = 3'h4;
  localparam logic [2:0] OT_CHAN_ONE       = 3'h1;
  localparam logic [2:0] OT_CHAN_FOUR      = 3'h4;
  localparam int         OT_MASK_ONE_BIT   = 0;
  localparam int         OT_MASK_FOUR_BIT  = 3;
  localparam logic [8:0] OT_HYST_DEGC      = 9'h004;

  localparam int         CLK_PERIOD_NS     = 5;
  localparam int         BUS_TIMEOUT_US    = 25000;

  typedef enum logic [1:0] {
    SCH_IDLE  = 2'b00,
    SCH_START = 2'b01,
    SCH_WAIT  = 2'b11
  } tmc_sched_state_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] cmd;
    logic [7:0] wdata;
  } tmc_reg_req_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] chan;
    logic [7:0] temp;
    logic [7:0] alert_limit;
    logic [7:0] ot_limit;
  } tmc_conv_res_t;

endpackage : tmc_pkg

// File: rtl/tmc_sync.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs asynchronous to clk_sys
// Notes:   first stage feeds only the second
`timescale 1ns/100ps
module tmc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_reg;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        meta_reg[i] <= 1'b1;
        dout[i]     <= 1'b1;
      end else if (ce) begin
        meta_reg[i] <= din[i];
        dout[i]     <= meta_reg[i];
      end
    end
  end

endmodule : tmc_sync

// File: rtl/tmc_bus_timeout.sv
// Purpose: serial clock stuck-low watchdog
// Assumes: scl already synchronised
// Notes:   one pulse per low period; re-arms on the next high level
`timescale 1ns/100ps
module tmc_bus_timeout #(
  parameter int unsigned CYCLES = 32'd5000000
) (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic ce,
  input  wire logic clr,
  input  wire logic enable,
  input  wire logic scl,
  output logic      timeout_pulse
);

  logic [31:0] low_cnt_reg;
  logic        fired_reg;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      low_cnt_reg   <= 32'h0;
      fired_reg     <= 1'b0;
      timeout_pulse <= 1'b0;
    end else if (ce) begin
      timeout_pulse <= 1'b0;
      if (clr || !enable || scl) begin
        low_cnt_reg <= 32'h0;
        fired_reg   <= 1'b0;
      end else if (!fired_reg) begin
        if (low_cnt_reg >= CYCLES - 32'd1) begin
          fired_reg     <= 1'b1;
          timeout_pulse <= 1'b1;
        end else begin
          low_cnt_reg <= low_cnt_reg + 32'd1;
        end
      end
    end
  end

endmodule : tmc_bus_timeout

// File: tb/tmc_conv_model.sv
// Purpose: converter stand-in that answers each conversion start with one result
// Assumes: one conversion in flight at a time, per-channel values set by the bench
// Notes:   idle result lines carry a moving pattern so stale data is never seen as valid
`timescale 1ns/100ps
module tmc_conv_model (
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic              conv_start,
  input  wire logic [2:0]        conv_chan,
  input  wire logic [2:0]        delay,
  input  wire logic [4:0][7:0]   temps,
  input  wire logic [4:0][7:0]   alims,
  input  wire logic [4:0][7:0]   olims,
  output tmc_pkg::tmc_conv_res_t conv_res
);
  logic       busy_reg;
  logic       v_reg;
  logic [2:0] cnt_reg;
  logic [2:0] ch_reg;
  logic [7:0] pat_reg;

  // delay is taken per conversion, so the bench can answer promptly or slowly
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      busy_reg <= 1'b0;
      v_reg    <= 1'b0;
      cnt_reg  <= 3'h0;
      ch_reg   <= 3'h0;
      pat_reg  <= 8'h00;
    end else begin
      v_reg   <= 1'b0;
      pat_reg <= pat_reg + 8'h01;
      if (conv_start) begin
        busy_reg <= 1'b1;
        cnt_reg  <= delay;
        ch_reg   <= conv_chan;
      end else if (busy_reg) begin
        if (cnt_reg == 3'h0) begin
          busy_reg <= 1'b0;
          v_reg    <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 3'h1;
        end
      end
    end
  end

  assign conv_res = v_reg ? {1'b1, ch_reg, temps[ch_reg], alims[ch_reg], olims[ch_reg]}
                          : {1'b0, pat_reg[2:0], pat_reg, ~pat_reg, pat_reg ^ 8'h5a};
endmodule : tmc_conv_model

// File: tb/tb_top.sv
// Purpose: self-checking bench of the temperature monitor control block
// Assumes: short bus timeout parameter, converter model on the result side
// Notes:   register and pin results are queued as notes and compared by a watcher
`timescale 1ns/100ps
module tb_top;
  typedef struct packed {
    logic [1:0] sel;
    logic [7:0] val;
  } tmc_note_t;

  logic                   clk_sys    = 1'b0;
  logic                   nrst       = 1'b0;
  logic                   smbclk_pin = 1'b1;
  logic                   ara_ack    = 1'b0;
  tmc_pkg::tmc_reg_req_t  req        = '0;
  tmc_pkg::tmc_conv_res_t res;
  logic [7:0]             reg_rdata;
  logic                   conv_start;
  logic [2:0]             conv_chan;
  logic                   canc, ta_o, ta_oe, ot_o, ot_oe, bto;
  logic [2:0]             dly        = 3'h0;
  logic [4:0][7:0]        temps      = {5{8'h90}};
  logic [4:0][7:0]        alims      = {5{8'h50}};
  logic [4:0][7:0]        olims      = {5{8'h7f}};
  logic [3:0][7:0]        seqc       = {8'h08, 8'h18, 8'h10, 8'h00};
  logic                   look = 1'b0, scl_run = 1'b0, scl_idle = 1'b1, seq_on = 1'b0;
  logic [7:0]             cfg1 = 8'h00, b, m;
  logic [31:0]            rnd = 32'h0000da6d;
  logic [2:0]             last_ch = 3'h0, last_n1 = 3'h0;
  tmc_note_t              notes[$];
  tmc_note_t              nt;
  int                     n_fail = 0, compares = 0, n_start = 0, n_to = 0, cyc = 0;
  int                     settle = 3, ch, s;

  tmc_ctrl #(.BUS_TIMEOUT_US(1)) dut_u (
    .clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .reg_req(req), .ara_ack(ara_ack),
    .conv_res(res), .smbclk_pin(smbclk_pin), .reg_rdata(reg_rdata), .conv_start(conv_start),
    .conv_chan(conv_chan), .conv_res_cancel(canc), .threshold_alarm_o(ta_o),
    .threshold_alarm_oe(ta_oe), .overtemp_o(ot_o), .overtemp_oe(ot_oe), .bus_timeout(bto));

  tmc_conv_model conv_u (
    .clk_sys(clk_sys), .nrst(nrst), .conv_start(conv_start), .conv_chan(conv_chan),
    .delay(dly), .temps(temps), .alims(alims), .olims(olims), .conv_res(res));

  always #2.5 clk_sys = ~clk_sys;

  // serial clock toggles only inside frames, offset from the core clock edges
  initial begin
    #1.3;
    forever begin
      #24;
      smbclk_pin = scl_run ? ~smbclk_pin : scl_idle;
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // fast mode puts channel one after every other channel
  function automatic logic [2:0] nxt(input logic [2:0] l, input logic [2:0] n1, input logic f);
    if (f && l != 3'h1) return 3'h1;
    if (f) return (n1 == 3'h4) ? 3'h0 : (n1 == 3'h0) ? 3'h2 : n1 + 3'h1;
    return (l == 3'h4) ? 3'h0 : l + 3'h1;
  endfunction : nxt

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    @(negedge clk_sys);
    req.wr    = 1'b1;
    req.cmd   = c;
    req.wdata = d;
    if (c == 8'h41) begin
      cfg1   = d;
      settle = 3;
    end
    @(negedge clk_sys);
    req.wr = 1'b0;
  endtask : wr

  task automatic note(input logic [1:0] sl, input logic [7:0] v);
    notes.push_back({sl, v});
    look = 1'b1;
    @(negedge clk_sys);
    look = 1'b0;
  endtask : note

  task automatic rdchk(input logic [7:0] c, input logic [7:0] v, input logic clr);
    @(negedge clk_sys);
    req.cmd = c;
    repeat (2) @(negedge clk_sys);
    note(2'h0, v);
    if (clr) begin
      req.rd = 1'b1;
      @(negedge clk_sys);
      req.rd = 1'b0;
    end
  endtask : rdchk

  // runs conversions for n cycles, then halts and lets the last one finish
  task automatic run(input logic [7:0] cfg, input int n);
    rnd = xs(rnd);
    dly = rnd[2:0];
    wr(8'h41, cfg);
    repeat (n) @(negedge clk_sys);
    wr(8'h41, cfg | 8'h80);
    repeat (40) @(negedge clk_sys);
  endtask : run

  always @(posedge clk_sys) begin
    cyc++;
    if (bto === 1'b1) n_to++;
    if (look === 1'b1) begin
      nt = notes.pop_front();
      case (nt.sel)
        2'h0:    check(reg_rdata, nt.val);
        2'h1:    check({6'h0, ta_o, ta_oe}, nt.val);
        default: check({6'h0, ot_o, ot_oe}, nt.val);
      endcase
    end
    if (conv_start === 1'b1) begin
      n_start++;
      if (settle > 0) settle--;
      else if (seq_on) begin
        check({5'h0, conv_chan}, {5'h0, nxt(last_ch, last_n1, cfg1[4])});
        check({7'h0, canc}, {7'h0, cfg1[3] && conv_chan == 3'h1});
      end
      last_ch = conv_chan;
      if (conv_chan != 3'h1) last_n1 = conv_chan;
    end
    if (cyc > 40000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    repeat (12) @(negedge clk_sys);
    nrst = 1'b1;
    for (int i = 0; i < 4; i++) rdchk(8'h41 + 8'(i), 8'h00, 1'b0);
    rdchk(8'h07, 8'h00, 1'b0);
    for (int i = 0; i < 6; i++) begin
      rnd = xs(rnd);
      wr(8'h42, rnd[7:0]);
      rdchk(8'h42, rnd[7:0] & 8'h4f, 1'b0);
      wr(8'h43, rnd[15:8]);
      rdchk(8'h43, rnd[15:8] & 8'h09, 1'b0);
      wr(8'h41, (rnd[23:16] & 8'hbf) | 8'h80);
      rdchk(8'h41, (rnd[23:16] & 8'hb8) | 8'h80, 1'b0);
      wr(8'h44, rnd[31:24]);
      rdchk(8'h44, 8'h00, 1'b0);
    end
    for (int k = 0; k < 5; k++) begin
      b = (k == 0) ? 8'h40 : 8'h01 << (k - 1);
      temps[k] = 8'h51;
      wr(8'h42, b);
      run(8'h00, 120);
      rdchk(8'h44, b, 1'b1);
      note(2'h1, 8'h00);
      rdchk(8'h44, 8'h00, 1'b0);
      wr(8'h42, ~b & 8'h4f);
      run(8'h00, 120);
      note(2'h1, 8'h01);
      rdchk(8'h44, b, 1'b0);
      if (k % 2) ara_ack = 1'b1;
      else req.rd = 1'b1;
      @(negedge clk_sys);
      ara_ack = 1'b0;
      req.rd  = 1'b0;
      repeat (3) @(negedge clk_sys);
      note(2'h1, 8'h00);
      rdchk(8'h44, (k % 2) ? b : 8'h00, 1'b1);
      temps[k] = 8'h90;
    end
    alims    = {5{8'h7f}};
    olims    = {5{8'h50}};
    temps[2] = 8'h51;
    for (int j = 0; j < 2; j++) begin
      ch = j ? 4 : 1;
      m  = j ? 8'h08 : 8'h01;
      temps[ch] = 8'h51;
      wr(8'h43, m);
      run(8'h00, 120);
      note(2'h2, 8'h00);
      wr(8'h43, 8'h00);
      run(8'h00, 120);
      note(2'h2, 8'h01);
      temps[ch] = 8'h4c;
      run(8'h00, 120);
      note(2'h2, 8'h01);
      temps[ch] = 8'h4b;
      run(8'h00, 120);
      note(2'h2, 8'h00);
    end
    temps[4] = 8'h51;
    run(8'h00, 120);
    wr(8'h42, 8'h4f);
    wr(8'h41, 8'h40);
    repeat (2) @(negedge clk_sys);
    note(2'h2, 8'h00);
    for (int i = 0; i < 3; i++) rdchk(8'h41 + 8'(i), 8'h00, 1'b0);
    temps[4] = 8'h90;
    seq_on = 1'b1;
    for (int i = 0; i < 4; i++) run(seqc[i], 150);
    seq_on = 1'b0;
    s = n_start;
    repeat (100) @(negedge clk_sys);
    check(8'(n_start - s), 8'h00);
    scl_run = 1'b1;
    repeat (60) @(negedge clk_sys);
    scl_run  = 1'b0;
    scl_idle = 1'b0;
    repeat (300) @(negedge clk_sys);
    check(8'(n_to), 8'h01);
    scl_idle = 1'b1;
    repeat (20) @(negedge clk_sys);
    wr(8'h41, 8'ha0);
    scl_idle = 1'b0;
    repeat (300) @(negedge clk_sys);
    check(8'(n_to), 8'h01);
    close_out();
  end
endmodule : tb_top
